// *** testbench/bsp_link_props.sv ***
// concurrent checks on the link between controller and device
`timescale 1ns/100ps
`default_nettype none
module bsp_link_props (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // link signals
    input wire logic        k_rise,
    input wire logic        kb_rise,
    input wire logic        dll_off_n,
    input wire logic        load_n,
    input wire logic        store_n,
    input wire logic [3:0]  lane_mask_n,
    input wire logic [35:0] rdata,
    input wire logic        rdata_oe,
    input wire logic        q_echo
);
    logic       last_load_r;
    logic       last_store_r;
    logic [3:0] rd_owed_r;
    logic [3:0] wr_beats_r;
    logic       wr_wait_r;
    logic [1:0] idle_r;
    logic       edge_any;
    logic       rd_acc;
    logic       wr_acc;

    assign edge_any = k_rise | kb_rise;
    assign rd_acc   = k_rise & ~load_n & last_load_r & dll_off_n;
    assign wr_acc   = k_rise & ~store_n & last_store_r & dll_off_n;

    // a read burst taken behind another adds its beats on top of the remainder
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            last_load_r  <= 1'b1;
            last_store_r <= 1'b1;
            rd_owed_r    <= 4'h0;
            wr_beats_r   <= 4'h0;
            wr_wait_r    <= 1'b0;
            idle_r       <= 2'h0;
        end else begin
            last_load_r  <= k_rise ? load_n : last_load_r;
            last_store_r <= k_rise ? store_n : last_store_r;
            rd_owed_r    <= rd_owed_r - 4'(q_echo) + (rd_acc ? 4'h4 : 4'h0);
            wr_wait_r    <= k_rise ? wr_acc : wr_wait_r;
            wr_beats_r   <= (k_rise && wr_wait_r) ? 4'h3 : wr_beats_r - 4'(edge_any && wr_beats_r != 4'h0);
            // counts half-edges, so a stopped clock never ages the release
            idle_r       <= (rd_owed_r != 4'h0 || q_echo) ? 2'h0 : idle_r + 2'(edge_any && idle_r != 2'h3);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_read_taken;
        rd_acc;
    endsequence
    // bound assumes a half period of at most three clocks
    sequence s_first_beat;
        ##[2:12] q_echo;
    endsequence

    read_answer_a: assert property (s_read_taken |-> s_first_beat) else $error("read not answered");
    echo_edge_a: assert property (q_echo |-> $past(edge_any)) else $error("beat off a clock edge");
    echo_owed_a: assert property (q_echo |-> rd_owed_r != 4'h0) else $error("beat with no read owed");
    echo_drive_a: assert property (q_echo |-> rdata_oe) else $error("beat while released");
    oe_release_a: assert property (idle_r >= 2'h2 |-> !rdata_oe) else $error("outputs not released");
    data_hold_a: assert property (!q_echo |-> $stable(rdata)) else $error("read data moved");
    mask_idle_a: assert property (edge_any && !wr_wait_r && wr_beats_r == 4'h0 |-> &lane_mask_n) else $error("mask low");
    load_space_a: assert property (k_rise && !load_n |-> last_load_r) else $error("read strobe repeated");
    store_space_a: assert property (k_rise && !store_n |-> last_store_r) else $error("write strobe repeated");
endmodule : bsp_link_props
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the controller and device pair
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import bsp_pkg::*;
    localparam int           LOCK = 8;
    localparam logic [143:0] D0   = 144'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210_1357;
    localparam logic [143:0] D1   = 144'hA5C3_96E1_0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2;
    logic         sys_clk      = 1'b0;
    logic         rst_b        = 1'b0;
    logic [7:0]   div_sel      = 8'h00;
    logic         clk_stop_req = 1'b0;
    logic         req_valid    = 1'b0;
    logic         req_write    = 1'b0;
    logic [7:0]   req_addr     = 8'h00;
    logic [143:0] req_wdata    = '0;
    logic [15:0]  req_mask_n   = 16'hFFFF;
    logic         dll_locked;
    logic         clk_stopped;
    logic         req_ready;
    logic         rd_valid;
    logic         dev_lock;
    logic [35:0]  rd_data;
    logic [143:0] got;
    logic [143:0] mem_a;
    int           miscompares  = 0;
    int           compares     = 0;
    int           echo_b       = 0;
    int           n;

    bsp_if #(.DATA_W(36), .ADDR_W(8)) lnk ();
    bsp_if #(.DATA_W(36), .ADDR_W(8)) lnk_b ();
    bsp_sram_ctl #(.LOCK_CYC(LOCK)) i_bsp_sram_ctl (.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk),
        .div_sel(div_sel), .clk_stop_req(clk_stop_req), .dll_locked(dll_locked), .clk_stopped(clk_stopped),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_mask_n(req_mask_n), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));
    bsp_sram_dev #(.LOCK_CYC(LOCK)) i_bsp_sram_dev (.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk),
        .dll_locked(dev_lock), .rd_active(), .wr_active());
    // second device sees a repeated read strobe
    bsp_sram_dev #(.LOCK_CYC(LOCK)) i_bsp_sram_dev_b (.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk_b),
        .dll_locked(), .rd_active(), .wr_active());
    bsp_link_props i_bsp_link_props (.sys_clk(sys_clk), .rst_b(rst_b), .k_rise(lnk.k_rise),
        .kb_rise(lnk.kb_rise), .dll_off_n(lnk.dll_off_n), .load_n(lnk.load_n), .store_n(lnk.store_n),
        .lane_mask_n(lnk.lane_mask_n), .rdata(lnk.rdata), .rdata_oe(lnk.rdata_oe), .q_echo(lnk.q_echo));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        lnk_b.k_rise <= ~lnk_b.k_rise;
        lnk_b.kb_rise <= lnk_b.k_rise;
    end
    always @(posedge sys_clk) begin
        if (lnk_b.q_echo === 1'b1) echo_b <= echo_b + 1;
    end

    task automatic check(input logic [143:0] seen, input logic [143:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic expire(input int cnt, input int lim);
        if (cnt >= lim) begin
            miscompares++;
            complete_run();
        end
    endtask : expire

    // expected lane merge: each mask bit gates its own nine data bits
    function automatic logic [143:0] merge(input logic [143:0] old_v, input logic [143:0] new_v,
                                           input logic [15:0] mk);
        logic [143:0] r;
        r = old_v;
        for (int i = 0; i < 16; i++) begin
            if (!mk[i]) r[i*9 +: 9] = new_v[i*9 +: 9];
        end
        return r;
    endfunction : merge

    task automatic access(input logic wr, input logic [7:0] a, input logic [143:0] wd, input logic [15:0] mk);
        int cnt;
        int b;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = wd;
        req_mask_n = mk;
        cnt = 0;
        @(posedge sys_clk);
        while (req_ready !== 1'b1) begin
            cnt++;
            expire(cnt, 500);
            @(posedge sys_clk);
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        got = '0;
        b = 0;
        cnt = 0;
        while (!wr && b < 4) begin
            if (rd_valid === 1'b1) begin
                got[b*36 +: 36] = rd_data;
                b++;
            end
            @(negedge sys_clk);
            cnt++;
            expire(cnt, 200);
        end
    endtask : access

    task automatic wait_lock();
        n = 0;
        while (dll_locked !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            expire(n, 3000);
        end
    endtask : wait_lock

    initial begin
        lnk_b.k_rise = 1'b0;
        lnk_b.kb_rise = 1'b0;
        lnk_b.dll_off_n = 1'b1;
        lnk_b.load_n = 1'b1;
        lnk_b.store_n = 1'b1;
        lnk_b.addr = 8'h00;
        lnk_b.wdata = '0;
        lnk_b.lane_mask_n = 4'hF;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        wait_lock();
        access(1'b1, 8'h05, D0, 16'h0000);
        access(1'b0, 8'h05, '0, 16'hFFFF);
        check(got, D0);
        // beats gate byte 0, byte 1, bytes 2 and 3, then nothing
        access(1'b1, 8'h05, D1, 16'hF3DE);
        mem_a = merge(D0, D1, 16'hF3DE);
        access(1'b0, 8'h05, '0, 16'hFFFF);
        check(got, mem_a);
        access(1'b1, 8'h06, ~D0, 16'h0000);
        access(1'b1, 8'h07, D1, 16'h0000);
        access(1'b0, 8'h06, '0, 16'hFFFF);
        check(got, ~D0);
        access(1'b0, 8'h07, '0, 16'hFFFF);
        check(got, D1);
        @(negedge sys_clk);
        clk_stop_req = 1'b1;
        n = 0;
        while (clk_stopped !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            expire(n, 200);
        end
        got = {108'h0, lnk.rdata};
        repeat (20) @(negedge sys_clk);
        check({106'h0, lnk.rdata, lnk.k_rise, lnk.rdata_oe}, {got[141:0], 2'b00});
        clk_stop_req = 1'b0;
        div_sel = 8'h01;
        n = 0;
        while (lnk.dll_off_n !== 1'b0) begin
            @(negedge sys_clk);
            n++;
            expire(n, 300);
        end
        repeat (BSP_DLL_RST_CYC) @(negedge sys_clk);
        check(lnk.dll_off_n, 1'b1);
        n = 0;
        while (dll_locked !== 1'b1) begin
            @(posedge sys_clk);
            if (lnk.k_rise === 1'b1) n++;
            expire(n, 100);
        end
        check(n >= LOCK, 1'b1);
        check(dev_lock, 1'b1);
        access(1'b0, 8'h05, '0, 16'hFFFF);
        check(got, mem_a);
        if (lnk_b.k_rise !== 1'b0) @(negedge sys_clk);
        lnk_b.load_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        lnk_b.load_n = 1'b1;
        repeat (20) @(negedge sys_clk);
        check(echo_b, 4);
        check(lnk_b.rdata_oe, 1'b0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire

// *** verilog/bsp_if.sv ***
// link between the memory controller and the burst sram device
`timescale 1ns/100ps
`default_nettype none
interface bsp_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 8
);
    localparam int LANES = DATA_W / 9;
    // input clock pair as half-edge enables
    logic              k_rise;
    logic              kb_rise;
    logic              dll_off_n;
    // command, address, write data
    logic              load_n;
    logic              store_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  lane_mask_n;
    // read data, echo and burst busy
    logic [DATA_W-1:0] rdata;
    logic              rdata_oe;
    logic              q_echo;
    logic              burst_busy;

    modport dev (
        input  k_rise, kb_rise, dll_off_n, load_n, store_n, addr, wdata, lane_mask_n,
        output rdata, rdata_oe, q_echo, burst_busy
    );
    modport ctl (
        output k_rise, kb_rise, dll_off_n, load_n, store_n, addr, wdata, lane_mask_n,
        input  rdata, rdata_oe, q_echo, burst_busy
    );
endinterface : bsp_if
`default_nettype wire

// *** verilog/bsp_pkg.sv ***
// shared constants and types for the burst sram port pair
package bsp_pkg;
    localparam int BSP_BEATS        = 4;
    localparam int BSP_LANE_W       = 9;
    localparam int BSP_DATA_W       = 36;
    localparam int BSP_ADDR_W       = 8;
    localparam int BSP_DIV_W        = 8;
    localparam int BSP_CLK_NS       = 25;
    localparam int BSP_DLL_LOCK_CYC = 2048;
    localparam int BSP_DLL_RST_NS   = 30;
    localparam int BSP_DLL_RST_CYC  = (BSP_DLL_RST_NS + BSP_CLK_NS - 1) / BSP_CLK_NS;
    localparam int BSP_CNT_W        = 12;
    localparam logic [2:0] BSP_LAST_BEAT = 3'h3;

    typedef enum logic [1:0] {
        BSP_DLL_RST,
        BSP_LOCK,
        BSP_RUN,
        BSP_STOP
    } bsp_ctl_state_type;
endpackage : bsp_pkg

// *** verilog/bsp_sram_ctl.sv ***
// memory controller end: clock divider, loop reset, command and data scheduling
`timescale 1ns/100ps
`default_nettype none
module bsp_sram_ctl
    import bsp_pkg::*;
#(
    parameter int DATA_W   = BSP_DATA_W,
    parameter int ADDR_W   = BSP_ADDR_W,
    parameter int LOCK_CYC = BSP_DLL_LOCK_CYC
) (
    // clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst_b,
    // link to device
    bsp_if.ctl                                lnk,
    // rate and clock stop control
    input  wire logic [BSP_DIV_W-1:0]         div_sel,
    input  wire logic                         clk_stop_req,
    output logic                              dll_locked,
    output logic                              clk_stopped,
    // request
    input  wire logic                         req_valid,
    input  wire logic                         req_write,
    input  wire logic [ADDR_W-1:0]            req_addr,
    input  wire logic [BSP_BEATS*DATA_W-1:0]  req_wdata,
    input  wire logic [BSP_BEATS*(DATA_W/9)-1:0] req_mask_n,
    output logic                              req_ready,
    // read return, one beat per pulse
    output logic                              rd_valid,
    output logic [DATA_W-1:0]                 rd_data
);
    localparam int LANES = DATA_W / BSP_LANE_W;

    bsp_ctl_state_type       st_r, st_nxt;
    logic [BSP_DIV_W-1:0]    div_r, div_nxt;
    logic [BSP_DIV_W-1:0]    dcnt_r, dcnt_nxt;
    logic                    phase_r, phase_nxt;
    logic                    kr_r, kr_nxt;
    logic                    kbr_r, kbr_nxt;
    logic [BSP_CNT_W-1:0]    cnt_r, cnt_nxt;
    logic                    load_n_r, load_n_nxt;
    logic                    store_n_r, store_n_nxt;
    logic [ADDR_W-1:0]       addr_r, addr_nxt;
    logic [BSP_BEATS*DATA_W-1:0] wnext_r, wnext_nxt, wbuf_r, wbuf_nxt;
    logic [BSP_BEATS*LANES-1:0]  mnext_r, mnext_nxt, mbuf_r, mbuf_nxt;
    logic [2:0]              wph_r, wph_nxt;
    logic [DATA_W-1:0]       wdata_r, wdata_nxt;
    logic [LANES-1:0]        mask_r, mask_nxt;
    logic                    rdv_r;
    logic [DATA_W-1:0]       rdd_r;
    logic                    run, edge_any, busy, take;

    assign run      = (st_r == BSP_LOCK) || (st_r == BSP_RUN);
    assign edge_any = kr_r | kbr_r;
    assign busy     = lnk.burst_busy | (wph_r != 3'h0) | ~load_n_r | ~store_n_r;
    // same strobe never presented on two primary edges in a row
    assign take = kr_r && (st_r == BSP_RUN) && req_valid && !clk_stop_req
               && (req_write ? store_n_r : load_n_r);
    assign req_ready = take;

    // divider and loop sequencing
    always_comb begin
        st_nxt    = st_r;
        div_nxt   = div_r;
        dcnt_nxt  = dcnt_r;
        phase_nxt = phase_r;
        kr_nxt    = 1'b0;
        kbr_nxt   = 1'b0;
        cnt_nxt   = cnt_r;
        if (run) begin
            if (dcnt_r == div_r) begin
                dcnt_nxt  = '0;
                phase_nxt = ~phase_r;
                kr_nxt    = ~phase_r;
                kbr_nxt   = phase_r;
            end else begin
                dcnt_nxt = dcnt_r + BSP_DIV_W'(1);
            end
        end
        case (st_r)
            BSP_DLL_RST: begin
                // clock held still and loop reset held for its minimum time
                if (cnt_r == BSP_CNT_W'(BSP_DLL_RST_CYC - 1)) begin
                    st_nxt  = BSP_LOCK;
                    cnt_nxt = '0;
                    div_nxt = div_sel;
                end else begin
                    cnt_nxt = cnt_r + BSP_CNT_W'(1);
                end
            end
            BSP_LOCK: begin
                if (div_sel != div_r) begin
                    st_nxt  = BSP_DLL_RST;
                    cnt_nxt = '0;
                end else if (kr_r) begin
                    if (cnt_r == BSP_CNT_W'(LOCK_CYC - 1)) begin
                        st_nxt = BSP_RUN;
                    end
                    cnt_nxt = cnt_r + BSP_CNT_W'(1);
                end
            end
            BSP_RUN: begin
                if (div_sel != div_r && !busy) begin
                    st_nxt  = BSP_DLL_RST;
                    cnt_nxt = '0;
                end else if (clk_stop_req && !busy && kr_r) begin
                    st_nxt = BSP_STOP;
                end
            end
            BSP_STOP: begin
                // the loop loses lock without a clock, so relock on restart
                if (!clk_stop_req) begin
                    st_nxt  = BSP_LOCK;
                    cnt_nxt = '0;
                end
            end
            default: st_nxt = BSP_DLL_RST;
        endcase
        if (st_nxt != BSP_LOCK && st_nxt != BSP_RUN) begin
            dcnt_nxt  = '0;
            phase_nxt = 1'b0;
        end
    end

    // command and write data scheduling
    always_comb begin
        load_n_nxt  = load_n_r;
        store_n_nxt = store_n_r;
        addr_nxt    = addr_r;
        wnext_nxt   = wnext_r;
        mnext_nxt   = mnext_r;
        wbuf_nxt    = wbuf_r;
        mbuf_nxt    = mbuf_r;
        wph_nxt     = wph_r;
        wdata_nxt   = wdata_r;
        mask_nxt    = mask_r;
        if (kr_r) begin
            load_n_nxt  = 1'b1;
            store_n_nxt = 1'b1;
            if (take) begin
                addr_nxt = req_addr;
                if (req_write) begin
                    store_n_nxt = 1'b0;
                    wnext_nxt   = req_wdata;
                    mnext_nxt   = req_mask_n;
                end else begin
                    load_n_nxt = 1'b0;
                end
            end
        end
        if (edge_any) begin
            if (wph_r != 3'h0) begin
                wdata_nxt = wbuf_r[(wph_r - 3'h1)*DATA_W +: DATA_W];
                mask_nxt  = mbuf_r[(wph_r - 3'h1)*LANES +: LANES];
                wph_nxt   = (wph_r == 3'(BSP_BEATS)) ? 3'h0 : wph_r + 3'h1;
            end else begin
                mask_nxt = '1;
            end
            if (kr_r && !store_n_r) begin
                wbuf_nxt = wnext_r;
                mbuf_nxt = mnext_r;
                wph_nxt  = 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r      <= BSP_DLL_RST;
            div_r     <= '0;
            dcnt_r    <= '0;
            phase_r   <= 1'b0;
            kr_r      <= 1'b0;
            kbr_r     <= 1'b0;
            cnt_r     <= '0;
            load_n_r  <= 1'b1;
            store_n_r <= 1'b1;
            addr_r    <= '0;
            wnext_r   <= '0;
            mnext_r   <= '1;
            wbuf_r    <= '0;
            mbuf_r    <= '1;
            wph_r     <= 3'h0;
            wdata_r   <= '0;
            mask_r    <= '1;
            rdv_r     <= 1'b0;
            rdd_r     <= '0;
        end else begin
            st_r      <= st_nxt;
            div_r     <= div_nxt;
            dcnt_r    <= dcnt_nxt;
            phase_r   <= phase_nxt;
            kr_r      <= kr_nxt;
            kbr_r     <= kbr_nxt;
            cnt_r     <= cnt_nxt;
            load_n_r  <= load_n_nxt;
            store_n_r <= store_n_nxt;
            addr_r    <= addr_nxt;
            wnext_r   <= wnext_nxt;
            mnext_r   <= mnext_nxt;
            wbuf_r    <= wbuf_nxt;
            mbuf_r    <= mbuf_nxt;
            wph_r     <= wph_nxt;
            wdata_r   <= wdata_nxt;
            mask_r    <= mask_nxt;
            rdv_r     <= lnk.q_echo;
            rdd_r     <= lnk.rdata;
        end
    end

    assign lnk.k_rise      = kr_r;
    assign lnk.kb_rise     = kbr_r;
    assign lnk.dll_off_n   = (st_r != BSP_DLL_RST);
    assign lnk.load_n      = load_n_r;
    assign lnk.store_n     = store_n_r;
    assign lnk.addr        = addr_r;
    assign lnk.wdata       = wdata_r;
    assign lnk.lane_mask_n = mask_r;
    assign dll_locked      = (st_r == BSP_RUN) || (st_r == BSP_STOP);
    assign clk_stopped     = (st_r == BSP_STOP);
    assign rd_valid        = rdv_r;
    assign rd_data         = rdd_r;
endmodule : bsp_sram_ctl
`default_nettype wire

// *** verilog/bsp_sram_dev.sv ***
// burst sram device end: command decode, read and write burst sequencing
`timescale 1ns/100ps
`default_nettype none
// Contract
// - frequency change needs a fresh loop reset
// - wait 2048 input cycles after loop reset
// - finish bursts; outputs hold while clock stopped
// - read beats at t+1, t+2 twice, t+3
// - write beats 1,2 at t+1; 3,4 at t+2
// - no same strobe on consecutive primary edges
// - repeated request on next edge is ignored
// - stale store strobe ignored, high recommended
// - masks sampled and driven on every beat
// - narrow width: two masks, one per byte
// - wide width: four masks, one per byte
// - masks honoured only inside started write bursts
// - fixed four-beat burst, address at primary edge
// - each mask gates its own nine bits
module bsp_sram_dev
    import bsp_pkg::*;
#(
    parameter int DATA_W   = BSP_DATA_W,
    parameter int ADDR_W   = BSP_ADDR_W,
    parameter int LOCK_CYC = BSP_DLL_LOCK_CYC
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // link to controller
    bsp_if.dev        lnk,
    // status
    output logic      dll_locked,
    output logic      rd_active,
    output logic      wr_active
);
    localparam int LANES = DATA_W / BSP_LANE_W;
    localparam int MEM_AW = ADDR_W + 2;

    logic [DATA_W-1:0] mem [2**MEM_AW];

    // command history and acceptance
    logic              load_prev_r, load_prev_nxt;
    logic              store_prev_r, store_prev_nxt;
    logic              rd_acc, wr_acc, any_edge;
    // read pipeline
    logic              rd_pend_r, rd_pend_nxt;
    logic [ADDR_W-1:0] rd_pend_addr_r, rd_pend_addr_nxt;
    logic              rd_arm_r, rd_arm_nxt;
    logic [ADDR_W-1:0] rd_arm_addr_r, rd_arm_addr_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic [2:0]        rd_cnt_r, rd_cnt_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic              oe_r, oe_nxt;
    logic              echo_r, echo_nxt;
    // write pipeline
    logic              wr_pend_r, wr_pend_nxt;
    logic [ADDR_W-1:0] wr_pend_addr_r, wr_pend_addr_nxt;
    logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [2:0]        wr_cnt_r, wr_cnt_nxt;
    logic              wr_beat;
    logic [MEM_AW-1:0] wr_idx;
    logic [LANES-1:0]  lane_we;
    // loop lock tracking
    logic [BSP_CNT_W-1:0] lock_cnt_r, lock_cnt_nxt;
    logic                 locked_r, locked_nxt;

    assign any_edge = lnk.k_rise | lnk.kb_rise;
    // a strobe counts only if it was high at the previous primary edge
    assign rd_acc = lnk.k_rise & lnk.dll_off_n & ~lnk.load_n & load_prev_r;
    assign wr_acc = lnk.k_rise & lnk.dll_off_n & ~lnk.store_n & store_prev_r;

    // command history, sampled only at primary edges
    always_comb begin
        load_prev_nxt  = load_prev_r;
        store_prev_nxt = store_prev_r;
        if (lnk.k_rise) begin
            load_prev_nxt  = lnk.load_n;
            store_prev_nxt = lnk.store_n;
        end
    end

    // read sequencing: accept, arm one cycle later, stream on half-edges
    always_comb begin
        rd_pend_nxt      = rd_pend_r;
        rd_pend_addr_nxt = rd_pend_addr_r;
        rd_arm_nxt       = rd_arm_r;
        rd_arm_addr_nxt  = rd_arm_addr_r;
        rd_addr_nxt      = rd_addr_r;
        rd_cnt_nxt       = rd_cnt_r;
        rdata_nxt        = rdata_r;
        oe_nxt           = oe_r;
        echo_nxt         = 1'b0;
        if (lnk.k_rise) begin
            rd_pend_nxt = rd_acc;
            rd_arm_nxt  = rd_pend_r;
            rd_arm_addr_nxt = rd_pend_addr_r;
            if (rd_acc) begin
                rd_pend_addr_nxt = lnk.addr;
            end
        end
        if (any_edge) begin
            if (lnk.kb_rise && rd_arm_r) begin
                // first beat on the complement edge of the next cycle
                rdata_nxt   = mem[{rd_arm_addr_r, 2'h0}];
                rd_addr_nxt = rd_arm_addr_r;
                rd_cnt_nxt  = BSP_LAST_BEAT;
                rd_arm_nxt  = 1'b0;
                oe_nxt      = 1'b1;
                echo_nxt    = 1'b1;
            end else if (rd_cnt_r != 3'h0) begin
                rdata_nxt  = mem[{rd_addr_r, 2'(3'(BSP_BEATS) - rd_cnt_r)}];
                rd_cnt_nxt = rd_cnt_r - 3'h1;
                oe_nxt     = 1'b1;
                echo_nxt   = 1'b1;
            end else begin
                // burst done and no new read: release the bus, data kept
                oe_nxt = 1'b0;
            end
        end
    end

    // write sequencing: beats on four half-edges starting one cycle later
    always_comb begin
        wr_pend_nxt      = wr_pend_r;
        wr_pend_addr_nxt = wr_pend_addr_r;
        wr_addr_nxt      = wr_addr_r;
        wr_cnt_nxt       = wr_cnt_r;
        wr_beat          = 1'b0;
        wr_idx           = {wr_addr_r, 2'h0};
        if (any_edge) begin
            if (lnk.k_rise && wr_pend_r) begin
                wr_beat     = 1'b1;
                wr_idx      = {wr_pend_addr_r, 2'h0};
                wr_addr_nxt = wr_pend_addr_r;
                wr_cnt_nxt  = BSP_LAST_BEAT;
            end else if (wr_cnt_r != 3'h0) begin
                wr_beat    = 1'b1;
                wr_idx     = {wr_addr_r, 2'(3'(BSP_BEATS) - wr_cnt_r)};
                wr_cnt_nxt = wr_cnt_r - 3'h1;
            end
        end
        if (lnk.k_rise) begin
            wr_pend_nxt = wr_acc;
            if (wr_acc) begin
                wr_pend_addr_nxt = lnk.addr;
            end
        end
    end

    // masks are sampled each beat but only a real write beat uses them
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            lane_we[i] = wr_beat & ~lnk.lane_mask_n[i];
        end
    end

    // loop lock: counts input cycles after the reset pin is released
    always_comb begin
        lock_cnt_nxt = lock_cnt_r;
        locked_nxt   = locked_r;
        if (!lnk.dll_off_n) begin
            lock_cnt_nxt = '0;
            locked_nxt   = 1'b0;
        end else if (lnk.k_rise && !locked_r) begin
            if (lock_cnt_r == BSP_CNT_W'(LOCK_CYC - 1)) begin
                locked_nxt = 1'b1;
            end
            lock_cnt_nxt = lock_cnt_r + BSP_CNT_W'(1);
        end
    end

    // with no input edge only the echo pulse and the lock count and lock flag under loop reset move, so outputs hold when stopped
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            load_prev_r    <= 1'b1;
            store_prev_r   <= 1'b1;
            rd_pend_r      <= 1'b0;
            rd_pend_addr_r <= '0;
            rd_arm_r       <= 1'b0;
            rd_arm_addr_r  <= '0;
            rd_addr_r      <= '0;
            rd_cnt_r       <= 3'h0;
            rdata_r        <= '0;
            oe_r           <= 1'b0;
            echo_r         <= 1'b0;
            wr_pend_r      <= 1'b0;
            wr_pend_addr_r <= '0;
            wr_addr_r      <= '0;
            wr_cnt_r       <= 3'h0;
            lock_cnt_r     <= '0;
            locked_r       <= 1'b0;
        end else begin
            load_prev_r    <= load_prev_nxt;
            store_prev_r   <= store_prev_nxt;
            rd_pend_r      <= rd_pend_nxt;
            rd_pend_addr_r <= rd_pend_addr_nxt;
            rd_arm_r       <= rd_arm_nxt;
            rd_arm_addr_r  <= rd_arm_addr_nxt;
            rd_addr_r      <= rd_addr_nxt;
            rd_cnt_r       <= rd_cnt_nxt;
            rdata_r        <= rdata_nxt;
            oe_r           <= oe_nxt;
            echo_r         <= echo_nxt;
            wr_pend_r      <= wr_pend_nxt;
            wr_pend_addr_r <= wr_pend_addr_nxt;
            wr_addr_r      <= wr_addr_nxt;
            wr_cnt_r       <= wr_cnt_nxt;
            lock_cnt_r     <= lock_cnt_nxt;
            locked_r       <= locked_nxt;
        end
    end

    // array write, one nine-bit lane per mask
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (lane_we[i]) begin
                mem[wr_idx][i*BSP_LANE_W +: BSP_LANE_W] <= lnk.wdata[i*BSP_LANE_W +: BSP_LANE_W];
            end
        end
    end

    assign lnk.rdata      = rdata_r;
    assign lnk.rdata_oe   = oe_r;
    assign lnk.q_echo     = echo_r;
    // pending work keeps the controller from stopping the clock
    assign lnk.burst_busy = rd_pend_r | rd_arm_r | (rd_cnt_r != 3'h0)
                          | wr_pend_r | (wr_cnt_r != 3'h0) | oe_r;
    assign dll_locked     = locked_r;
    assign rd_active      = rd_arm_r | (rd_cnt_r != 3'h0);
    assign wr_active      = wr_cnt_r != 3'h0;
endmodule : bsp_sram_dev
`default_nettype wire
